/* inc/adc_trig_defines.vh */
// Constants for the timer-triggered converter sequencer: register map,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the rtl files.
`ifndef ADC_TRIG_DEFINES_VH
`define ADC_TRIG_DEFINES_VH

// ------------------------------------------------------------
// Register word offsets (byte addresses, word aligned)
// ------------------------------------------------------------
`define OFS_CONV_MODE_CTRL0 8'h00
`define OFS_CONV_MODE_CTRL2 8'h04
`define OFS_CHAN_SELECT 8'h08
`define OFS_CMP_FUNC_MODE 8'h0C
`define OFS_CMP_FUNC_THRESHOLD 8'h10
`define OFS_STATUS 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_MASK 8'h1C
`define OFS_RESULT_BASE 8'h40
`define OFS_RESULT_LAST 8'h6C

// ------------------------------------------------------------
// Field positions in conv_mode_ctrl0
// ------------------------------------------------------------
`define BIT_CONV_ENABLE 7
`define BIT_OP_MODE_HI 5
`define BIT_OP_MODE_LO 4
`define BIT_HIGH_SPEED 0

// Field positions in conv_mode_ctrl2
`define BIT_TRIG_SRC_SEL_HI 1
`define BIT_TRIG_SRC_SEL_LO 0
`define BIT_TIMER_MODE 4

// Status register bits
`define BIT_STAT_BUSY 0
`define BIT_STAT_STABLE 1

// Interrupt status bits
`define IRQ_CONV_END 0
`define IRQ_ABORT 1
`define IRQ_RESTART 2

// ------------------------------------------------------------
// Reset values and sizes
// ------------------------------------------------------------
`define RST_CTRL 8'h00
`define RST_RESULT 10'h000
`define NUM_CHAN 12
`define RESULT_W 10

// ------------------------------------------------------------
// Timing: 250 MHz clock, 4 ns period
// ------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define STAB_TIME_NS 1000
`define STAB_CYCLES ((`STAB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TIME_NS 200
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* rtl/adc_timer_trigger_sequencer.v */
// Timer-triggered converter sequencer with Avalon-MM register slave.
// Assumes one 250 MHz clock, timer matches and converter data synchronous
// to it, and an Avalon-MM master that honours waitrequest.
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adc_trig_defines.vh"
module adc_timer_trigger_sequencer
#(
  parameter CONV_CYCLES = `CONV_CYCLES,
  parameter STAB_CYCLES = `STAB_CYCLES
)
(
  input wire clk,
  input wire resetn,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire timer_match_a,
  input wire timer_match_b,
  input wire [`RESULT_W-1:0] adc_sample,
  output reg [3:0] analog_sel,
  output reg sample_hold,
  output reg conv_in_progress,
  output reg conv_end_irq,
  output wire irq
);

  // ------------------------------------------------------------
  // Reset synchroniser
  // ------------------------------------------------------------
  // First and second stage of release
  reg rst_s1_q;
  reg rst_n_q;

  // Async assert, clocked release
  // Only the second stage is read by the rest of the design
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_STAB = 2'b01;
  localparam ST_WAIT = 2'b10;
  localparam ST_CONV = 2'b11;

  // Control registers
  reg [7:0] mode_ctrl0_q;
  reg [7:0] mode_ctrl2_q;
  reg [3:0] chan_sel_q;
  reg [7:0] cmp_mode_q;
  reg [7:0] cmp_thr_q;
  // Interrupt status and mask
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  // Result store, one word per channel
  reg [`RESULT_W-1:0] result_q [0:`NUM_CHAN-1];
  // Sequencer state and step counter
  reg [1:0] state_q;
  reg [7:0] step_q;
  // Channel latched at conversion start
  reg [3:0] conv_chan_q;
  // Read answered one cycle after request
  reg rd_done_q;

  // Internal events and decoded fields
  wire trig_edge;
  wire stable;
  wire conv_enable;
  wire [1:0] trig_src_sel;
  wire [1:0] op_mode;
  wire wr_ok;
  wire rd_ok;
  wire ctrl_wr;
  wire done;
  wire restart;
  wire abort;

  assign conv_enable = mode_ctrl0_q[`BIT_CONV_ENABLE];
  assign op_mode = {mode_ctrl0_q[`BIT_OP_MODE_HI], mode_ctrl0_q[`BIT_OP_MODE_LO]};
  assign trig_src_sel = {mode_ctrl2_q[`BIT_TRIG_SRC_SEL_HI],
                         mode_ctrl2_q[`BIT_TRIG_SRC_SEL_LO]};

  // ------------------------------------------------------------
  // Address decoding
  // ------------------------------------------------------------
  // True when address hits a control register that aborts conversion
  function is_ctrl;
    input [7:0] a;
    begin
      is_ctrl = (a == `OFS_CONV_MODE_CTRL0) || (a == `OFS_CONV_MODE_CTRL2) ||
                (a == `OFS_CHAN_SELECT) || (a == `OFS_CMP_FUNC_MODE) ||
                (a == `OFS_CMP_FUNC_THRESHOLD);
    end
  endfunction

  // Byte lane 0 must be enabled for any field to change
  // Writes never stall, so a write lands on the edge it is seen
  // Writes complete at once; reads wait one cycle for registered data
  assign wr_ok = avs_write;
  assign rd_ok = avs_read & rd_done_q;
  assign avs_waitrequest = avs_read & ~rd_done_q;
  assign ctrl_wr = wr_ok & avs_byteenable[0] & is_ctrl(avs_address);

  // ------------------------------------------------------------
  // Sub-blocks
  // ------------------------------------------------------------
  // timer match sources
  trig_edge_detect u_edge
  (
    .clk(clk),
    .rst_n(rst_n_q),
    .timer_match_a(timer_match_a),
    .timer_match_b(timer_match_b),
    .trig_src_sel(trig_src_sel),
    .trig_edge(trig_edge)
  );

  // Stabilization wait, rerun on every enable rise
  stab_timer #(.STAB_CYCLES(STAB_CYCLES)) u_stab
  (
    .clk(clk),
    .rst_n(rst_n_q),
    .enable(conv_enable),
    .stable(stable)
  );

  // ------------------------------------------------------------
  // Sequencer events
  // ------------------------------------------------------------
  // Step counter runs 0 to CONV_CYCLES-1 while converting
  // Last step ends the run; a control write in that cycle wins
  assign done = (state_q == ST_CONV) && (step_q == CONV_CYCLES[7:0] - 8'h01) && !ctrl_wr;
  assign restart = (state_q == ST_CONV) && trig_edge && !ctrl_wr;
  // Abort outranks restart, restart outranks the end
  assign abort = (state_q == ST_CONV) && ctrl_wr;

  // ------------------------------------------------------------
  // Sequencer state machine
  // ------------------------------------------------------------
  // IDLE to STAB on enable, STAB to WAIT once stable,
  // WAIT to CONV on an edge, CONV to WAIT on end or abort
  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= ST_IDLE;
      step_q <= 8'h00;
      conv_chan_q <= 4'h0;
    end
    else if (!conv_enable)
    begin
      // Disable drops everything, no result stored
      state_q <= ST_IDLE;
      step_q <= 8'h00;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          state_q <= ST_STAB;
        ST_STAB:
          if (stable)
            state_q <= ST_WAIT;
        ST_WAIT:
          if (trig_edge && !ctrl_wr)
          begin
            conv_chan_q <= chan_sel_q;
            step_q <= 8'h00;
            state_q <= ST_CONV;
          end
        ST_CONV:
          if (abort)
          begin
            state_q <= ST_WAIT;
            step_q <= 8'h00;
          end
          else if (restart)
          begin
            conv_chan_q <= chan_sel_q;
            step_q <= 8'h00;
          end
          else if (done)
          begin
            state_q <= ST_WAIT;
            step_q <= 8'h00;
          end
          else
            step_q <= step_q + 8'h01;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Converter outputs and busy flag
  // ------------------------------------------------------------
  // busy follows conversion
  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      conv_in_progress <= 1'b0;
      conv_end_irq <= 1'b0;
      analog_sel <= 4'h0;
      sample_hold <= 1'b0;
    end
    else
    begin
      // Next-state view, so the flag rises with the first converting cycle
      conv_in_progress <= conv_enable && ((state_q == ST_WAIT && trig_edge && !ctrl_wr) ||
                          (state_q == ST_CONV && !abort && (!done || restart)));
      conv_end_irq <= conv_enable && done && !restart;
      if (state_q == ST_WAIT || restart)
        analog_sel <= chan_sel_q;
      // Sample pulse follows each clear of the step counter that leaves
      // the sequencer in CONV, so a restart samples the input again
      sample_hold <= conv_enable && (state_q == ST_CONV) && (step_q == 8'h00);
    end
  end

  // ------------------------------------------------------------
  // Result store
  // ------------------------------------------------------------
  // Store only when a run ends cleanly; aborts and restarts
  // leave the old word in place
  // store for all op modes
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CHAN; gi = gi + 1)
    begin : g_res
      always @(posedge clk or negedge rst_n_q)
      begin
        if (!rst_n_q)
          result_q[gi] <= `RST_RESULT;
        else if (conv_enable && done && !restart && conv_chan_q == gi)
          result_q[gi] <= adc_sample;
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Register writes and interrupt status
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      mode_ctrl0_q <= `RST_CTRL;
      mode_ctrl2_q <= `RST_CTRL;
      chan_sel_q <= 4'h0;
      cmp_mode_q <= `RST_CTRL;
      cmp_thr_q <= `RST_CTRL;
      irq_mask_q <= 3'h0;
      irq_stat_q <= 3'h0;
      rd_done_q <= 1'b0;
    end
    else
    begin
      rd_done_q <= avs_read & ~rd_done_q;
      if (wr_ok && avs_byteenable[0])
      begin
        // Only the low byte holds fields
        case (avs_address)
          `OFS_CONV_MODE_CTRL0: mode_ctrl0_q <= avs_writedata[7:0];
          `OFS_CONV_MODE_CTRL2: mode_ctrl2_q <= avs_writedata[7:0];
          `OFS_CHAN_SELECT:
            // Out of range channel numbers are ignored
            if (avs_writedata[3:0] < 4'hC)
              chan_sel_q <= avs_writedata[3:0];
          `OFS_CMP_FUNC_MODE: cmp_mode_q <= avs_writedata[7:0];
          `OFS_CMP_FUNC_THRESHOLD: cmp_thr_q <= avs_writedata[7:0];
          `OFS_IRQ_MASK: irq_mask_q <= avs_writedata[2:0];
          default: ;
        endcase
      end
      // Read clears only the bits captured into readdata; an event that
      // lands between capture and clear would otherwise be lost.
      // A new event in the clearing cycle still wins.
      irq_stat_q <= ((rd_ok && avs_address == `OFS_IRQ_STATUS) ?
                     (irq_stat_q & ~avs_readdata[2:0]) : irq_stat_q) |
                    {restart, abort, conv_enable && done && !restart};
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Reads are answered from this register one cycle after request,
  // which keeps the decode out of the bus return path
  // Captured at request so it stands when waitrequest drops
  always @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !rd_done_q)
    begin
      case (avs_address)
        `OFS_CONV_MODE_CTRL0: avs_readdata <= {24'h000000, mode_ctrl0_q};
        `OFS_CONV_MODE_CTRL2: avs_readdata <= {24'h000000, mode_ctrl2_q};
        `OFS_CHAN_SELECT: avs_readdata <= {28'h0000000, chan_sel_q};
        `OFS_CMP_FUNC_MODE: avs_readdata <= {24'h000000, cmp_mode_q};
        `OFS_CMP_FUNC_THRESHOLD: avs_readdata <= {24'h000000, cmp_thr_q};
        `OFS_STATUS: avs_readdata <= {28'h0000000, op_mode, stable, conv_in_progress};
        `OFS_IRQ_STATUS: avs_readdata <= {29'h00000000, irq_stat_q};
        `OFS_IRQ_MASK: avs_readdata <= {29'h00000000, irq_mask_q};
        default:
          // Result words; anything unmapped reads zero
          if (avs_address >= `OFS_RESULT_BASE && avs_address <= `OFS_RESULT_LAST &&
              avs_address[1:0] == 2'b00)
            avs_readdata <= {22'h000000, result_q[avs_address[5:2] - 4'h0]};
          else
            avs_readdata <= 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

/* rtl/stab_timer.v */
// Stabilization timer: counts once after the enable bit rises.
// Assumes enable is a register level in the clk domain.
`timescale 1ns/1ps
`default_nettype none
`include "adc_trig_defines.vh"
module stab_timer
#(
  parameter STAB_CYCLES = `STAB_CYCLES
)
(
  input wire clk,
  input wire rst_n,
  input wire enable,
  output wire stable
);

  // Enable level of previous cycle
  reg en_prev_q;
  // Remaining stabilization cycles
  reg [15:0] cnt_q;
  // Period has elapsed
  reg done_q;

  // ------------------------------------------------------------
  // Countdown
  // ------------------------------------------------------------
  // load on enable rise
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_prev_q <= 1'b0;
      cnt_q <= 16'h0000;
      done_q <= 1'b0;
    end
    else
    begin
      en_prev_q <= enable;
      if (!enable)
      begin
        // Disabled: next enable inserts the wait again
        cnt_q <= 16'h0000;
        done_q <= 1'b0;
      end
      else if (!en_prev_q)
      begin
        cnt_q <= STAB_CYCLES[15:0];
        done_q <= 1'b0;
      end
      else if (cnt_q > 16'h0001)
        cnt_q <= cnt_q - 16'h0001;
      else
        done_q <= 1'b1;
    end
  end

  assign stable = done_q;

endmodule
`default_nettype wire

/* rtl/trig_edge_detect.v */
// Trigger source mux and rising edge detector for the timer matches.
// Assumes timer match inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module trig_edge_detect
(
  input wire clk,
  input wire rst_n,
  input wire timer_match_a,
  input wire timer_match_b,
  input wire [1:0] trig_src_sel,
  output wire trig_edge
);

  // Previous sample of the selected request
  reg prev_q;
  // Selected request level
  reg sel_level;

  // ------------------------------------------------------------
  // Source selection
  // ------------------------------------------------------------
  // field picks source
  always @*
  begin
    // Codes 00 and 01 pick match a, 1x picks match b
    if (trig_src_sel[1])
      sel_level = timer_match_b;
    else
      sel_level = timer_match_a;
  end

  // ------------------------------------------------------------
  // Edge detection
  // ------------------------------------------------------------
  // registered previous sample
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_q <= 1'b0;
    else
      prev_q <= sel_level;
  end

  assign trig_edge = sel_level & ~prev_q;

endmodule
`default_nettype wire

/* test/adc_seq_monitor.sv */
// Port checker for the timer-triggered sequencer.
// Assumes match lines and bus are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_monitor
#(
  parameter CONV_CYCLES = 50,
  parameter STAB_CYCLES = 250
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic timer_match_a,
  input wire logic timer_match_b,
  input wire logic [3:0] analog_sel,
  input wire logic sample_hold,
  input wire logic conv_in_progress,
  input wire logic conv_end_irq
);
  localparam int BUSY_MAX = 300;
  logic a_q, b_q, rise_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // Helper: any match rise, seen one cycle late
  // ------------------------------------------------------------
  // Lines up with the start cycle of the busy flag
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      rise_q <= 1'b0;
    end
    else
    begin
      a_q <= timer_match_a;
      b_q <= timer_match_b;
      rise_q <= (timer_match_a & ~a_q) | (timer_match_b & ~b_q);
    end
  end
  // Busy rises with the registered edge, the sample pulse one cycle later
  sequence s_start;
    rise_q && conv_in_progress ##1 sample_hold;
  endsequence
  sequence s_end;
    conv_end_irq ##1 !conv_end_irq;
  endsequence
  a_start_on_edge: assert property ($rose(conv_in_progress) |-> s_start)
    else $error("busy rose without a match edge");
  a_hold_on_edge: assert property (sample_hold |-> $past(rise_q))
    else $error("sample pulse without a match edge");
  a_end_one_pulse: assert property (conv_end_irq |-> s_end)
    else $error("end pulse longer than one cycle");
  a_end_frees_busy: assert property (conv_end_irq |-> !conv_in_progress)
    else $error("busy still high at end pulse");
  a_end_after_run: assert property (conv_end_irq |-> $past(conv_in_progress))
    else $error("end pulse without a running conversion");
  a_busy_bounded: assert property (
    sample_hold |-> ##[1:BUSY_MAX] (!conv_in_progress || sample_hold))
    else $error("conversion never returned to wait");
  a_sel_range: assert property (conv_in_progress |-> analog_sel < 4'hC)
    else $error("channel out of range while busy");
  a_sel_steady: assert property (conv_in_progress && !sample_hold |-> $stable(analog_sel))
    else $error("channel moved during conversion");
endmodule
bind adc_timer_trigger_sequencer adc_seq_monitor
  #(.CONV_CYCLES(CONV_CYCLES), .STAB_CYCLES(STAB_CYCLES))
  u_mon (.clk(clk), .resetn(resetn), .timer_match_a(timer_match_a),
  .timer_match_b(timer_match_b), .analog_sel(analog_sel), .sample_hold(sample_hold),
  .conv_in_progress(conv_in_progress), .conv_end_irq(conv_end_irq));
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the timer-triggered sequencer.
// Assumes short counts; the match model shares clk with the bus tasks.
`timescale 1ns/1ps
`default_nettype none
`include "adc_trig_defines.vh"
module testbench;
  localparam int CONV_T = 6;
  localparam int STAB_T = 4;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [9:0] adc_sample = 10'h000;
  wire logic [31:0] avs_readdata;
  wire logic [3:0] analog_sel;
  wire logic avs_waitrequest, tm_a, tm_b, sample_hold, conv_in_progress, conv_end_irq, irq;
  int n_errors = 0;
  int tests_run = 0;
  int n_end = 0;
  logic [31:0] q;
  // ------------------------------------------------------------
  // Clock, design and match source
  // ------------------------------------------------------------
  initial
  begin
    forever #2 clk = ~clk;
  end
  adc_timer_trigger_sequencer #(.CONV_CYCLES(CONV_T), .STAB_CYCLES(STAB_T))
    u_adc_timer_trigger_sequencer
    (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer_match_a(tm_a),
    .timer_match_b(tm_b), .adc_sample(adc_sample), .analog_sel(analog_sel),
    .sample_hold(sample_hold), .conv_in_progress(conv_in_progress),
    .conv_end_irq(conv_end_irq), .irq(irq));
  tmr_match u_tmr_match (.clk(clk), .match_a(tm_a), .match_b(tm_b));
  // Count end pulses away from the launching edge
  always @(negedge clk)
  begin
    if (conv_end_irq === 1'b1)
      n_end++;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic complete_run;
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Held until waitrequest is seen low before the taking edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d = 8'h00);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= !wr;
    avs_write <= wr;
    #1;
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 20)
    begin
      n_errors++;
      complete_run();
    end
    @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Fresh reset per setup, so every scenario starts from reset register values
  task automatic arm(input logic [3:0] ch, input logic sb, input logic [1:0] md, input logic m,
    input logic ws);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b1, `OFS_IRQ_MASK, {7'h00, m});
    bus(1'b1, `OFS_CHAN_SELECT, {4'h0, ch});
    bus(1'b1, `OFS_CONV_MODE_CTRL2, {6'h04, sb, 1'b0});
    bus(1'b1, `OFS_CONV_MODE_CTRL0, {2'h2, md, 4'h1});
    if (ws)
      repeat (STAB_T + 4) @(posedge clk);
  endtask
  task automatic conv(input logic sb, input logic [3:0] ch);
    adc_sample <= {6'h28, ch};
    u_tmr_match.pulse(sb, 2);
    #1;
    chk("busy", 32'h1, conv_in_progress);
    chk("channel", ch, analog_sel);
  endtask
  task automatic wait_end(input int e);
    int c;
    c = 0;
    while (conv_end_irq !== 1'b1 && c < 30)
    begin
      @(posedge clk);
      #1;
      c++;
    end
    chk("end delay", e, c);
    // A run that never ends is a hang unless the scenario expects none
    if (c == 30 && e != 30)
      complete_run();
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_stab;
    arm(4'h2, 1'b0, 2'h0, 1'b1, 1'b0);
    u_tmr_match.pulse(1'b0, 2);
    #1;
    chk("early busy", 32'h0, conv_in_progress);
    repeat (STAB_T + 4) @(posedge clk);
    bus(1'b0, `OFS_STATUS);
    chk("standby status", 32'h2, q);
    conv(1'b0, 4'h2);
    wait_end(CONV_T - 1);
  endtask
  task automatic t_modes;
    logic [3:0] chs [4] = '{4'h0, 4'h5, 4'hA, 4'hB};
    for (int i = 0; i < 4; i++)
    begin
      arm(chs[i], i[0], i[1:0], i != 3, 1'b1);
      conv(i[0], chs[i]);
      wait_end(CONV_T - 1);
      chk("irq", i != 3, irq);
      bus(1'b0, `OFS_RESULT_BASE + {2'h0, chs[i], 2'h0});
      chk("result", {22'h000000, 6'h28, chs[i]}, q);
      bus(1'b0, `OFS_STATUS);
      chk("status", {28'h0000000, i[1:0], 2'h2}, q);
      bus(1'b0, `OFS_IRQ_STATUS);
      #1;
      chk("irq status", 32'h1, q);
      chk("irq cleared", 32'h0, irq);
    end
  endtask
  task automatic t_level;
    int n0;
    arm(4'h7, 1'b1, 2'h0, 1'b1, 1'b1);
    n0 = n_end;
    u_tmr_match.pulse(1'b1, 3 * CONV_T);
    repeat (4) @(posedge clk);
    chk("level starts", 32'h1, n_end - n0);
  endtask
  task automatic t_restart;
    arm(4'h3, 1'b0, 2'h0, 1'b1, 1'b1);
    conv(1'b0, 4'h3);
    u_tmr_match.pulse(1'b0, 2);
    #1;
    wait_end(CONV_T - 1);
    bus(1'b0, `OFS_IRQ_STATUS);
    chk("restart status", 32'h5, q);
  endtask
  task automatic t_abort;
    arm(4'h4, 1'b1, 2'h0, 1'b1, 1'b1);
    conv(1'b1, 4'h4);
    bus(1'b1, `OFS_CHAN_SELECT, 8'h06);
    wait_end(30);
    bus(1'b0, `OFS_RESULT_BASE + 8'h10);
    chk("aborted result", 32'h0, q);
    bus(1'b0, `OFS_IRQ_STATUS);
    chk("abort status", 32'h2, q);
    bus(1'b0, 8'h30);
    chk("unmapped", 32'h0, q);
    bus(1'b1, `OFS_CHAN_SELECT, 8'h0C);
    bus(1'b0, `OFS_CHAN_SELECT);
    chk("channel refused", 32'h6, q);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    t_stab();
    t_modes();
    t_level();
    t_restart();
    t_abort();
    complete_run();
  end
endmodule
`default_nettype wire

/* test/tmr_match.sv */
// Timer compare match source for the two trigger request lines.
// Assumes callers step it from clk; lines change only after edges.
`timescale 1ns/1ps
`default_nettype none
module tmr_match
(
  input wire logic clk,
  output logic match_a,
  output logic match_b
);
  // ------------------------------------------------------------
  // Match request lines
  // ------------------------------------------------------------
  // Both idle low, so the first request is a clean rise
  initial
  begin
    match_a = 1'b0;
    match_b = 1'b0;
  end
  task automatic pulse(input logic sel_b, input int len);
    @(posedge clk);
    if (sel_b)
      match_b <= 1'b1;
    else
      match_a <= 1'b1;
    repeat (len) @(posedge clk);
    match_a <= 1'b0;
    match_b <= 1'b0;
  endtask
endmodule
`default_nettype wire
